// file: common/dds_pkg.sv
// Purpose: Shared widths, codes, reset values and carrier types of the DDS core
// Assumes: One reference clock; control fields arrive already deserialised
// Notes:   The increment arithmetic lives here because the core and its checks share it
package dds_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int ACC_W      = 24;
  localparam int FREQ_W     = 22;
  localparam int DEV_W      = 8;
  localparam int DEV_LSB    = 2;
  localparam int DAC_W      = 11;
  localparam int LUT_ADDR_W = 5;
  localparam int LUT_DATA_W = 10;
  localparam int GAIN_W     = 3;
  localparam int PA_W       = 2;
  localparam int SYNC_W     = 4;

  //////////////////////////////////////////////////////////////////////////////
  // Codes
  localparam logic [1:0] PA_CODE_OFF  = 2'h0;
  localparam logic [1:0] PA_CODE_10DB = 2'h1;
  localparam logic [1:0] PA_CODE_20DB = 2'h2;
  localparam logic [1:0] PA_CODE_0DB  = 2'h3;
  localparam logic       MM_FSK       = 1'h0;
  localparam logic       DIV_512      = 1'h1;
  localparam logic [1:0] QUAD_HALF    = 2'h2;
  localparam logic [10:0] DAC_MID_HI  = 11'h400;
  localparam logic [10:0] DAC_MID_LO  = 11'h3FF;

  //////////////////////////////////////////////////////////////////////////////
  // Carriers
  typedef struct packed {
    logic pll_en;
    logic vco_en;
    logic pa_level_bit_high;
    logic pa_level_bit_low;
  } dds_mode_ctl_type;

  typedef struct packed {
    logic [FREQ_W-1:0] mode0_freq_setting;
    logic [FREQ_W-1:0] mode1_freq_setting;
    logic              modulation_method_bit;
    logic [DEV_W-1:0]  fsk_shift_value;
    logic              div512_sel;
    logic [GAIN_W-1:0] acq_pump_gain_field;
    dds_mode_ctl_type  mode0_ctl;
    dds_mode_ctl_type  mode1_ctl;
  } dds_cfg_type;

  typedef struct packed {
    logic mode_sel;
    logic tx_data;
    logic run;
    logic pll_lock;
  } dds_pins_type;

  typedef struct packed {
    logic              pll_en;
    logic              vco_en;
    logic              div512_sel;
    logic              acq_pump_en;
    logic [GAIN_W-1:0] acq_gain;
    logic              pa_en;
    logic [PA_W-1:0]   pa_atten_code;
    logic              tx_mod_en;
  } dds_rf_ctl_type;

  typedef struct packed {
    dds_cfg_type      cfg;
    logic [ACC_W-1:0] inc;
    logic [ACC_W-1:0] acc;
    dds_rf_ctl_type   ctl;
  } dds_core_state_type;

  //////////////////////////////////////////////////////////////////////////////
  // Reset values (power-up: everything off, all settings zero)
  localparam dds_cfg_type    CFG_RST = '0;
  localparam dds_rf_ctl_type CTL_RST = '0;
  localparam logic [ACC_W-1:0] ACC_RST = 24'h000000;

  //////////////////////////////////////////////////////////////////////////////
  // Increment for the selected mode and keyed data
  function automatic logic [ACC_W-1:0] dds_freq_inc(input dds_cfg_type cfg,
                                                   input logic        mode1,
                                                   input logic        tx_hi);
    logic [ACC_W-1:0] base;
    logic [ACC_W-1:0] dev;
    base = {2'h0, (mode1 ? cfg.mode1_freq_setting : cfg.mode0_freq_setting)};
    dev  = {14'h0000, cfg.fsk_shift_value, 2'h0};
    if (cfg.modulation_method_bit == MM_FSK && tx_hi) begin
      dds_freq_inc = base + dev;
    end else begin
      dds_freq_inc = base;
    end
  endfunction

  function automatic dds_mode_ctl_type dds_mode_ctl(input dds_cfg_type cfg,
                                                    input logic        mode1);
    dds_mode_ctl = mode1 ? cfg.mode1_ctl : cfg.mode0_ctl;
  endfunction

endpackage

// file: rtl/dds_sync2.sv
// Purpose: Two-flop synchroniser for the asynchronous control pins
// Assumes: Each bit is an independent level
// Notes:   Stage one is read only by stage two
module dds_sync2
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic              core_clk,
  input  wire logic              sys_rst,
  // Pins
  input  wire logic [SYNC_W-1:0] async_in,
  output logic      [SYNC_W-1:0] sync_out
);

  typedef struct packed {
    logic [SYNC_W-1:0] meta;
    logic [SYNC_W-1:0] safe;
  } dds_sync_state_type;

  dds_sync_state_type st_r;
  dds_sync_state_type st_nxt;

  always_comb begin
    st_nxt.meta = async_in;
    st_nxt.safe = st_r.meta;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.safe;

endmodule

// file: rtl/dds_sine_rom.sv
// Purpose: Quarter-wave sine table with registered offset-binary output
// Assumes: Phase arrives as the top seven accumulator bits
// Notes:   Quarter symmetry keeps the table at 32 words
module dds_sine_rom
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  // Phase in, sample out
  input  wire logic [6:0]         phase,
  output logic      [DAC_W-1:0]   sample
);

  localparam logic [LUT_DATA_W-1:0] QTAB [32] = '{
    10'h019, 10'h04B, 10'h07D, 10'h0AF, 10'h0E0, 10'h111, 10'h141, 10'h170,
    10'h19F, 10'h1CC, 10'h1F8, 10'h223, 10'h24D, 10'h275, 10'h29C, 10'h2C1,
    10'h2E5, 10'h307, 10'h326, 10'h344, 10'h360, 10'h37A, 10'h392, 10'h3A8,
    10'h3BB, 10'h3CB, 10'h3DA, 10'h3E6, 10'h3F0, 10'h3F7, 10'h3FC, 10'h3FF
  };

  typedef struct packed {
    logic [DAC_W-1:0] data;
  } dds_rom_state_type;

  dds_rom_state_type st_r;
  dds_rom_state_type st_nxt;

  always_comb begin
    logic [LUT_ADDR_W-1:0] addr;
    logic [LUT_DATA_W-1:0] mag;
    addr = phase[5] ? ~phase[4:0] : phase[4:0];
    mag  = QTAB[addr];
    // First half-cycle (phase[6] low) sits above mid-scale, second half below it
    if (phase[6]) begin
      st_nxt.data = DAC_MID_LO - {1'h0, mag};
    end else begin
      st_nxt.data = DAC_MID_HI + {1'h0, mag};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sample = st_r.data;

endmodule

// file: rtl/dds_fsk_core.sv
// Purpose: DDS phase accumulator with two-mode FSK increment and RF control decode
// Assumes: core_clk is the reference oscillator; settings come from a loader on core_clk
// Notes:   Settings are held here and survive standby; only sys_rst clears them
//
// Function
// - 24-bit accumulator updated every reference clock while run is high
// - Accumulator adds frequency register each clock while running, holds in standby
// - Accumulator output indexes sine table for DAC
// - 22-bit settings, top two bits zero
// - Mode 0 and mode 1 settings separate
// - Mode pin selects which setting loads
// - FSK active when modulation method bit zero
// - Deviation weighted four accumulator LSBs
// - Transmit data high adds four times deviation
// - Settings retained through standby
// - Control bit selects divide 256 or 512
// - Three-bit acquisition pump gain field
// - Acquisition pump on only while unlocked
// - Two-bit field sets power level
// - PA code decode; nonzero enables modulation
module dds_fsk_core
  import dds_pkg::*;
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Settings from the control-word loader
  input  wire logic             cfg_load,
  input  wire dds_cfg_type      cfg_in,
  // Asynchronous pins
  input  wire logic             mode_sel_pin,
  input  wire logic             tx_data_pin,
  input  wire logic             run_pin,
  input  wire logic             pll_lock_pin,
  // Synthesiser outputs
  output logic      [ACC_W-1:0] phase_out,
  output logic      [DAC_W-1:0] dac_sample,
  output dds_rf_ctl_type        rf_ctl,
  output dds_cfg_type           cfg_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers

  dds_pins_type pin_a;
  dds_pins_type pin_s;

  assign pin_a = '{mode_sel: mode_sel_pin, tx_data: tx_data_pin,
                   run: run_pin, pll_lock: pll_lock_pin};

  dds_sync2 u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .async_in (pin_a),
    .sync_out (pin_s)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  dds_core_state_type st_r;
  dds_core_state_type st_nxt;

  always_comb begin
    dds_mode_ctl_type mc;
    logic [1:0]       pa;
    st_nxt = st_r;
    mc     = dds_mode_ctl(st_r.cfg, pin_s.mode_sel);
    pa     = {mc.pa_level_bit_high, mc.pa_level_bit_low};

    // Loader writes only here; standby never touches the settings
    if (cfg_load) begin
      st_nxt.cfg = cfg_in;
    end

    // Increment follows the synchronised pins one edge later
    st_nxt.inc = dds_freq_inc(st_r.cfg, pin_s.mode_sel, pin_s.tx_data);

    // Plain 24-bit add: carry out is dropped, the ramp simply wraps
    if (pin_s.run) begin
      st_nxt.acc = st_r.acc + st_r.inc;
    end

    if (pin_s.run) begin
      st_nxt.ctl.pll_en        = mc.pll_en;
      st_nxt.ctl.vco_en        = mc.vco_en;
      st_nxt.ctl.div512_sel    = st_r.cfg.div512_sel;
      st_nxt.ctl.acq_gain      = st_r.cfg.acq_pump_gain_field;
      st_nxt.ctl.acq_pump_en   = mc.pll_en && !pin_s.pll_lock;
      st_nxt.ctl.pa_en         = (pa != PA_CODE_OFF);
      st_nxt.ctl.tx_mod_en     = (pa != PA_CODE_OFF);
      st_nxt.ctl.pa_atten_code = pa;
    end else begin
      // Standby: everything analog off, settings kept for a fast restart
      st_nxt.ctl = CTL_RST;
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r.cfg <= CFG_RST;
      st_r.inc <= ACC_RST;
      st_r.acc <= ACC_RST;
      st_r.ctl <= CTL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sine lookup

  dds_sine_rom u_rom (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .phase    (st_r.acc[ACC_W-1 -: 7]),
    .sample   (dac_sample)
  );

  assign phase_out = st_r.acc;
  assign rf_ctl    = st_r.ctl;
  assign cfg_out   = st_r.cfg;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_mode_flip;
    $changed(pin_s.mode_sel);
  endsequence

  sequence s_inc_follows;
    st_r.inc == dds_freq_inc($past(st_r.cfg), $past(pin_s.mode_sel), $past(pin_s.tx_data));
  endsequence

  sequence s_running2;
    pin_s.run [*2];
  endsequence

  property p_acc_step;
    s_running2 |-> st_r.acc == ACC_W'($past(st_r.acc) + $past(st_r.inc));
  endproperty

  acc_step_a: assert property (p_acc_step)
    else $error("accumulator did not add the increment");

  acc_hold_a: assert property (!$past(pin_s.run) && !$past(sys_rst) |-> $stable(st_r.acc))
    else $error("accumulator moved during standby");

  inc_sel_a: assert property (s_mode_flip |=> s_inc_follows)
    else $error("increment not reloaded after mode change");

  inc_fsk_a: assert property ($past(pin_s.tx_data) && !$past(sys_rst)
      && $past(st_r.cfg.modulation_method_bit) == MM_FSK
      |-> st_r.inc == {2'h0, ($past(pin_s.mode_sel) ? $past(st_r.cfg.mode1_freq_setting)
                                 : $past(st_r.cfg.mode0_freq_setting))}
                      + {14'h0000, $past(st_r.cfg.fsk_shift_value), 2'h0})
    else $error("keyed increment is not setting plus four times deviation");

  inc_plain_a: assert property ((!$past(pin_s.tx_data) || $past(st_r.cfg.modulation_method_bit))
      && !$past(sys_rst) |-> st_r.inc[ACC_W-1 -: 2] == 2'h0)
    else $error("unkeyed increment exceeds 22 bits");

  dac_half_a: assert property (!$past(sys_rst) && !$past(sys_rst, 2)
      |-> dac_sample[DAC_W-1] == !$past(st_r.acc[ACC_W-1]))
    else $error("sample half-cycle does not match phase");

  acq_pump_a: assert property (st_r.ctl.acq_pump_en |-> $past(!pin_s.pll_lock))
    else $error("acquisition pump on while locked");

  pa_decode_a: assert property (st_r.ctl.pa_en |-> st_r.ctl.tx_mod_en
      && st_r.ctl.pa_atten_code != PA_CODE_OFF)
    else $error("power amplifier decode inconsistent");

  cfg_keep_a: assert property (!cfg_load |=> $stable(st_r.cfg))
    else $error("settings changed without a load");

  div_sel_a: assert property ($past(pin_s.run) && !$past(sys_rst)
      |-> st_r.ctl.div512_sel == $past(st_r.cfg.div512_sel)
       && st_r.ctl.acq_gain == $past(st_r.cfg.acq_pump_gain_field))
    else $error("divider or gain not taken from settings");

  ////////////////////////////////////////////////////////////////////////////
  // Check helpers: what the increment and decode logic see on this edge

  dds_mode_ctl_type  sel_ctl;
  logic [FREQ_W-1:0] sel_freq;
  logic [ACC_W:0]    acc_sum;

  assign sel_ctl  = dds_mode_ctl(st_r.cfg, pin_s.mode_sel);
  assign sel_freq = pin_s.mode_sel ? st_r.cfg.mode1_freq_setting
                                   : st_r.cfg.mode0_freq_setting;
  // One extra bit so the checks can see the carry that the core throws away
  assign acc_sum  = {1'h0, st_r.acc} + {1'h0, st_r.inc};

  sequence s_clean_prev;
    !$past(sys_rst);
  endsequence

  sequence s_live_prev;
    $past(pin_s.run) && !$past(sys_rst);
  endsequence

  sequence s_stby_prev;
    !$past(pin_s.run) && !$past(sys_rst);
  endsequence

  sequence s_sync_clean;
    !$past(sys_rst) && !$past(sys_rst, 2);
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Ramp and wrap

  acc_carry_a: assert property (s_live_prev ##0 $past(acc_sum[ACC_W])
      |-> st_r.acc < $past(st_r.acc))
    else $error("accumulator carry did not wrap the ramp");

  acc_ramp_a: assert property (s_live_prev ##0 !$past(acc_sum[ACC_W])
      |-> st_r.acc >= $past(st_r.acc))
    else $error("accumulator ramp fell without a carry");

  acc_low_a: assert property (s_live_prev
      |-> st_r.acc == $past(acc_sum[ACC_W-1:0]))
    else $error("accumulator is not the low 24 bits of the sum");

  ////////////////////////////////////////////////////////////////////////////
  // Increment shape

  inc_base_a: assert property (s_clean_prev ##0
      ($past(st_r.cfg.modulation_method_bit) != MM_FSK || !$past(pin_s.tx_data))
      |-> st_r.inc == {2'h0, $past(sel_freq)})
    else $error("unkeyed increment differs from the selected setting");

  inc_lsb_a: assert property (s_clean_prev
      |-> st_r.inc[1:0] == $past(sel_freq[1:0]))
    else $error("deviation disturbed the two low increment bits");

  inc_max_a: assert property (s_clean_prev |-> st_r.inc <= 24'h4003FB)
    else $error("increment above largest setting plus deviation");

  // Pins reach the logic exactly two edges after they are sampled
  sync_lag_a: assert property (s_sync_clean |-> pin_s == $past(pin_a, 2))
    else $error("pin synchroniser latency is not two edges");

  ////////////////////////////////////////////////////////////////////////////
  // RF control decode

  pump_lock_a: assert property (s_live_prev ##0 $past(sel_ctl.pll_en)
      |-> st_r.ctl.acq_pump_en == !$past(pin_s.pll_lock))
    else $error("acquisition pump does not follow lock state");

  pump_pll_a: assert property (st_r.ctl.acq_pump_en |-> st_r.ctl.pll_en)
    else $error("acquisition pump on with loop disabled");

  ctl_sel_a: assert property (s_live_prev
      |-> st_r.ctl.pll_en == $past(sel_ctl.pll_en)
       && st_r.ctl.vco_en == $past(sel_ctl.vco_en))
    else $error("loop enables not taken from the selected mode");

  pa_code_a: assert property (s_live_prev
      |-> st_r.ctl.pa_atten_code
          == $past({sel_ctl.pa_level_bit_high, sel_ctl.pa_level_bit_low}))
    else $error("power level not taken from the selected mode");

  pa_off_a: assert property (st_r.ctl.pa_atten_code == PA_CODE_OFF
      |-> !st_r.ctl.pa_en && !st_r.ctl.tx_mod_en)
    else $error("power amplifier on with the off code");

  pa_mod_a: assert property (st_r.ctl.tx_mod_en == st_r.ctl.pa_en)
    else $error("modulation enable differs from amplifier enable");

  // Standby drops every analog enable, the pump included
  stby_ctl_a: assert property (s_stby_prev |-> st_r.ctl == CTL_RST)
    else $error("analog controls active during standby");

  ////////////////////////////////////////////////////////////////////////////
  // Settings and sine half-cycles

  cfg_take_a: assert property (cfg_load |=> st_r.cfg == $past(cfg_in))
    else $error("settings not captured on load");

  cfg_stby_a: assert property (s_stby_prev ##0 !$past(cfg_load)
      |-> st_r.cfg == $past(st_r.cfg))
    else $error("settings changed during standby");

  dac_low_a: assert property (s_clean_prev ##0 $past(st_r.acc[ACC_W-1])
      |-> dac_sample <= DAC_MID_LO)
    else $error("second half-cycle sample above mid-scale");

  dac_high_a: assert property (s_clean_prev ##0 !$past(st_r.acc[ACC_W-1])
      |-> dac_sample >= DAC_MID_HI)
    else $error("first half-cycle sample below mid-scale");

endmodule

// file: testbench/dds_pll_model.sv
// Purpose: Behavioural loop partner that reports lock after a settling time
// Assumes: Lock needs the loop enabled and a live sine reference from the DAC
// Notes:   Lock drops at once when the loop is disabled, as a real loop would lose it
module dds_pll_model
  import dds_pkg::*;
#(
  parameter int LOCK_CYC = 12
)
(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             sys_rst,
  // Far side of the core
  input  wire dds_rf_ctl_type   rf_ctl,
  input  wire logic [DAC_W-1:0] dac_sample,
  output logic                  pll_lock
);
  timeunit 1ns;
  timeprecision 1ps;

  int unsigned cnt_r;

  // Lock state feeds the core's pump decision
  always_ff @(posedge core_clk) begin
    if (sys_rst || !rf_ctl.pll_en || dac_sample == 11'h000) begin
      cnt_r    <= '0;
      pll_lock <= 1'h0;
    end else if (cnt_r == LOCK_CYC) begin
      pll_lock <= 1'h1;
    end else begin
      cnt_r <= cnt_r + 1;
    end
  end
endmodule

// file: testbench/dds_fsk_frequency_synth_tb_top.sv
// Purpose: Self-checking bench of the DDS core through its settings and pins
// Assumes: Pins change 1 ns after a rising edge; outputs are read there too
// Notes:   Steps are measured as phase differences, so wrap-around is checked for free
module dds_fsk_frequency_synth_tb_top
  import dds_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic             core_clk;
  logic             sys_rst;
  logic             cfg_load;
  logic             mode_sel_pin;
  logic             tx_data_pin;
  logic             run_pin;
  logic             pll_lock_pin;
  dds_cfg_type      cfg_in;
  dds_cfg_type      cfg_out;
  dds_rf_ctl_type   rf_ctl;
  logic [ACC_W-1:0] phase_out;
  logic [DAC_W-1:0] dac_sample;
  int               failures;
  int               check_count;

  dds_fsk_core uut (.core_clk(core_clk), .sys_rst(sys_rst), .cfg_load(cfg_load),
    .cfg_in(cfg_in), .mode_sel_pin(mode_sel_pin), .tx_data_pin(tx_data_pin),
    .run_pin(run_pin), .pll_lock_pin(pll_lock_pin), .phase_out(phase_out),
    .dac_sample(dac_sample), .rf_ctl(rf_ctl), .cfg_out(cfg_out));

  dds_pll_model u_pll (.core_clk(core_clk), .sys_rst(sys_rst), .rf_ctl(rf_ctl),
    .dac_sample(dac_sample), .pll_lock(pll_lock_pin));

  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end

  //////////////////////////////////////////////////////////////////////////////
  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic cmp_val(input logic [ACC_W-1:0] got, input logic [ACC_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp_ctl(input dds_rf_ctl_type exp);
    check_count++;
    if (rf_ctl !== exp) begin
      failures++;
      $display("ERROR t=%0t rf_ctl %h expected %h", $time, rf_ctl, exp);
    end
  endtask

  task automatic cmp_cfg(input dds_cfg_type exp);
    check_count++;
    if (cfg_out !== exp) begin
      failures++;
      $display("ERROR t=%0t cfg_out %h expected %h", $time, cfg_out, exp);
    end
  endtask

  task automatic load();
    cfg_load = 1'h1;
    tick(1);
    cfg_load = 1'h0;
    cmp_cfg(cfg_in);
  endtask

  task automatic pins(input logic m, input logic t, input logic r);
    mode_sel_pin = m;
    tx_data_pin  = t;
    run_pin      = r;
  endtask

  // One step of the accumulator, and the sine half that the previous phase selects
  task automatic meas(input logic [ACC_W-1:0] exp);
    logic [ACC_W-1:0] p0;
    p0 = phase_out;
    tick(1);
    cmp_val(phase_out - p0, exp);
    cmp_val({23'h000000, dac_sample[10]}, {23'h000000, ~p0[23]});
  endtask

  task automatic wait_pump_off();
    int i;
    // The reference sits at the bottom of the sine for a long stretch here,
    // so lock may take about a hundred cycles
    for (i = 0; i < 200 && rf_ctl.acq_pump_en !== 1'h0; i++) tick(1);
    if (i == 200) begin
      failures++;
      $display("ERROR t=%0t pump never switched off", $time);
      give_verdict();
    end
  endtask

  function automatic dds_rf_ctl_type exp_ctl(input logic lock);
    dds_mode_ctl_type m;
    m = mode_sel_pin ? cfg_in.mode1_ctl : cfg_in.mode0_ctl;
    exp_ctl = '0;
    if (run_pin) begin
      exp_ctl.pll_en        = m.pll_en;
      exp_ctl.vco_en        = m.vco_en;
      exp_ctl.div512_sel    = cfg_in.div512_sel;
      exp_ctl.acq_pump_en   = m.pll_en & ~lock;
      exp_ctl.acq_gain      = cfg_in.acq_pump_gain_field;
      exp_ctl.pa_atten_code = {m.pa_level_bit_high, m.pa_level_bit_low};
      exp_ctl.pa_en         = m.pa_level_bit_high | m.pa_level_bit_low;
      exp_ctl.tx_mod_en     = m.pa_level_bit_high | m.pa_level_bit_low;
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    failures    = 0;
    check_count = 0;
    sys_rst     = 1'h1;
    cfg_load    = 1'h0;
    cfg_in      = '0;
    pins(1'h0, 1'h0, 1'h0);
    // Two edges clear the synchronisers and the table as well
    tick(2);
    sys_rst = 1'h0;
    cmp_val(phase_out, 24'h000000);
    cmp_cfg('0);
    cmp_ctl('0);
    cfg_in.mode0_freq_setting    = 22'h3FFFFF;
    cfg_in.mode1_freq_setting    = 22'h000123;
    cfg_in.fsk_shift_value       = 8'hFF;
    cfg_in.div512_sel            = DIV_512;
    cfg_in.acq_pump_gain_field   = 3'h5;
    cfg_in.mode0_ctl             = 4'h5;
    cfg_in.mode1_ctl             = 4'hB;
    load();
    pins(1'h0, 1'h0, 1'h1);
    tick(5);
    repeat (6) meas(24'h3FFFFF);
    cmp_ctl(exp_ctl(1'h0));
    pins(1'h0, 1'h1, 1'h1);
    tick(2);
    meas(24'h3FFFFF);
    tick(3);
    meas(24'h4003FB);
    pins(1'h1, 1'h1, 1'h1);
    tick(5);
    meas(24'h00051F);
    cmp_ctl(exp_ctl(1'h0));
    wait_pump_off();
    cmp_ctl(exp_ctl(1'h1));
    for (int c = 0; c < 4; c++) begin
      cfg_in.mode1_ctl.pa_level_bit_high = c[1];
      cfg_in.mode1_ctl.pa_level_bit_low  = c[0];
      load();
      tick(3);
      cmp_ctl(exp_ctl(1'h1));
    end
    cfg_in.modulation_method_bit = 1'h1;
    load();
    tick(3);
    meas(24'h000123);
    pins(1'h1, 1'h1, 1'h0);
    tick(5);
    meas(24'h000000);
    cmp_ctl('0);
    cmp_cfg(cfg_in);
    pins(1'h1, 1'h1, 1'h1);
    tick(5);
    meas(24'h000123);
    give_verdict();
  end
endmodule
